/* logic/ptg_echo_mem.sv */
// echo buffer storage with registered read data
`timescale 1ns/100ps
module ptg_echo_mem
	import ptg_pkg::*;
(
	input wire logic clk,
	input wire logic wr_en,
	input wire logic [ECHO_AW-1:0] wr_addr,
	input wire logic [WORD_W-1:0] wr_data,
	input wire logic [ECHO_AW-1:0] rd_addr,
	output logic [WORD_W-1:0] rd_data
);

	logic [WORD_W-1:0] mem [0:(1<<ECHO_AW)-1];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end

endmodule

/* logic/ptg_pkg.sv */
// constants and shared helpers for the test pattern generator
//==========================================================
// Summary of operation
// - pattern 0 sends alternating 1010 word
// - pattern 1 sends five ones, five zeros
// - pattern 2 sends ten ones, ten zeros
// - pattern 3 is PRBS7 x^7+x^6+1, true
// - pattern 4 is PRBS9 x^9+x^5+1, true
// - pattern 5 is PRBS11 x^11+x^9+1, true
// - pattern 6 is PRBS15 x^15+x^14+1, inverted
// - pattern 7 is PRBS20 x^20+x^3+1, true
// - pattern 8 is PRBS23 x^23+x^18+1, inverted
// - pattern 9 is PRBS29 x^29+x^27+1, inverted
// - pattern 10 is PRBS31 x^31+x^28+1, inverted
// - pattern 12 alternates positive and negative commas
// - pattern 13 repeats programmable symbols, comma default
// - PRBS built as Fibonacci shift register
// - stages k and n XOR into stage one
// - low speed settings 20-bit, high 40-bit
// - transmit logic clocked by transceiver output clock
// - channel index picks bottom or top edge
// - three native loopbacks plus fabric echo
// - echo buffers and resends received words
// - echo buffer drops data, never stalls
// - loopback codes 01, 10 serial; 11 parallel
// - comma symbols 0011111010 and 1100000101
package ptg_pkg;

	localparam int WORD_W = 40;
	localparam int NARROW_W = 20;
	localparam int SYM_W = 10;
	localparam int LFSR_W = 31;
	localparam int ECHO_AW = 4;

	// register byte offsets
	localparam logic [3:0] OFF_CTRL = 4'h0;
	localparam logic [3:0] OFF_USER01 = 4'h4;
	localparam logic [3:0] OFF_USER23 = 4'h8;
	localparam logic [3:0] OFF_STATUS = 4'hC;

	// control field positions
	localparam int CTRL_PAT_LSB = 0;
	localparam int CTRL_SPEED_LSB = 4;
	localparam int CTRL_LOOP_LSB = 7;
	localparam int CTRL_ECHO_BIT = 9;
	localparam int CTRL_RESEED_BIT = 10;
	localparam int USER_HI_LSB = 16;

	// status field positions
	localparam int STAT_WIDE_BIT = 0;
	localparam int STAT_OVF_BIT = 1;
	localparam int STAT_UNF_BIT = 2;
	localparam int STAT_EDGE_BIT = 3;
	localparam int STAT_LEVEL_LSB = 8;

	// serial speed setting codes; codes 4 and up are the wide group
	localparam logic [2:0] SPD_28_20 = 3'h0;
	localparam logic [2:0] SPD_27_20 = 3'h1;
	localparam logic [2:0] SPD_25_20 = 3'h2;
	localparam logic [2:0] SPD_24_20 = 3'h3;
	localparam logic [2:0] SPD_23_40 = 3'h4;
	localparam logic [2:0] SPD_21_40 = 3'h5;
	localparam logic [2:0] SPD_20_40 = 3'h6;
	localparam logic [2:0] SPD_13_40 = 3'h7;

	// loopback codes driven to the transceiver
	localparam logic [1:0] LOOP_NONE = 2'h0;
	localparam logic [1:0] LOOP_POST_SERIAL = 2'h1;
	localparam logic [1:0] LOOP_PRE_SERIAL = 2'h2;
	localparam logic [1:0] LOOP_PARALLEL = 2'h3;

	localparam logic [SYM_W-1:0] COMMA_POS = 10'h0FA;
	localparam logic [SYM_W-1:0] COMMA_NEG = 10'h305;

	localparam logic [WORD_W-1:0] CLK2_WORD = 40'h55_5555_5555;
	localparam logic [WORD_W-1:0] CLK10_WORD = 40'h07_C1F0_7C1F;
	localparam logic [WORD_W-1:0] CLK20_WORD = 40'h00_3FF0_03FF;

	localparam logic [LFSR_W-1:0] LFSR_SEED = 31'h7FFF_FFFF;
	localparam logic [3:0] CTRL_PAT_RESET = 4'h0;
	localparam logic [2:0] CTRL_SPEED_RESET = SPD_28_20;

	typedef enum logic [3:0] {
		PTG_CLK2, PTG_CLK10, PTG_CLK20, PTG_PRBS7, PTG_PRBS9, PTG_PRBS11,
		PTG_PRBS15, PTG_PRBS20, PTG_PRBS23, PTG_PRBS29, PTG_PRBS31,
		PTG_RSVD11, PTG_IDLE, PTG_USER, PTG_RSVD14, PTG_RSVD15
	} ptg_pattern_t;

	// speed codes 4..7 run 40-bit words
	function automatic logic ptg_is_wide(input logic [2:0] spd);
		return spd[2];
	endfunction

endpackage

/* logic/ptg_top.sv */
// transmit test pattern generator with loopback select and echo path
//
// Register access over Avalon-MM and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module ptg_top
	import ptg_pkg::*;
#(
	parameter int CHANNEL_INDEX = 0
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [WORD_W-1:0] rx_word,
	input wire logic rx_word_valid,
	output logic [WORD_W-1:0] tx_word,
	output logic tx_wide_group,
	output logic [1:0] loopback_sel,
	output logic edge_top
);

	//==========================================================
	// functions
	// one word of serial bits, bit 0 sent first; returns {state, word}
	function automatic logic [LFSR_W+WORD_W-1:0] prbs_step(
		input logic [LFSR_W-1:0] st,
		input logic [4:0] n,
		input logic [4:0] k,
		input logic wide
	);
		logic [LFSR_W-1:0] s;
		logic [LFSR_W-1:0] mask;
		logic [WORD_W-1:0] w;
		logic fb;
		s = st;
		mask = LFSR_W'((32'h1 << n) - 32'h1);
		w = '0;
		fb = 1'b0;
		for (int i = 0; i < WORD_W; i++) begin
			if (wide || i < NARROW_W) begin
				fb = s[n-5'd1] ^ s[k-5'd1];
				w[i] = s[n-5'd1];
				s = ((s << 1) | LFSR_W'(fb)) & mask;
			end
		end
		return {s, w};
	endfunction

	function automatic logic [31:0] sym_pair(input logic [SYM_W-1:0] lo, input logic [SYM_W-1:0] hi);
		return {6'h00, hi, 6'h00, lo};
	endfunction

	//==========================================================
	// registers
	logic [3:0] pattern_reg;
	logic [2:0] speed_reg;
	logic [1:0] loop_reg;
	logic echo_en_reg;
	logic reseed_reg;
	logic [SYM_W-1:0] user_sym_reg [0:3];
	logic ovf_reg;
	logic unf_reg;
	logic [31:0] rdata_reg;
	logic wait_reg;
	logic [LFSR_W-1:0] lfsr_reg;
	logic [WORD_W-1:0] tx_reg;
	logic wide_reg;
	logic [1:0] loop_out_reg;
	logic edge_reg;

	//==========================================================
	// bus decode
	wire bus_req = avs_read | avs_write;
	wire bus_commit = bus_req & ~wait_reg;
	wire wr_ctrl = bus_commit & avs_write & (avs_address == OFF_CTRL);
	wire wr_u01 = bus_commit & avs_write & (avs_address == OFF_USER01);
	wire wr_u23 = bus_commit & avs_write & (avs_address == OFF_USER23);
	wire wr_stat = bus_commit & avs_write & (avs_address == OFF_STATUS);
	wire [31:0] wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

	wire [31:0] ctrl_rd = {21'h0, 1'b0, echo_en_reg, loop_reg, speed_reg, pattern_reg};
	wire [ECHO_AW:0] echo_level;
	wire [31:0] stat_rd = {16'h0, 3'h0, echo_level, 4'h0, edge_reg, unf_reg, ovf_reg, wide_reg};
	wire [31:0] ctrl_new = (ctrl_rd & ~wmask) | (avs_writedata & wmask);
	wire [31:0] u01_new = (sym_pair(user_sym_reg[0], user_sym_reg[1]) & ~wmask) | (avs_writedata & wmask);
	wire [31:0] u23_new = (sym_pair(user_sym_reg[2], user_sym_reg[3]) & ~wmask) | (avs_writedata & wmask);
	wire [31:0] stat_clr = avs_writedata & wmask;

	logic [31:0] rd_mux;
	always_comb begin
		case (avs_address)
			OFF_CTRL: rd_mux = ctrl_rd;
			OFF_USER01: rd_mux = sym_pair(user_sym_reg[0], user_sym_reg[1]);
			OFF_USER23: rd_mux = sym_pair(user_sym_reg[2], user_sym_reg[3]);
			OFF_STATUS: rd_mux = stat_rd;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// one wait cycle, then the request completes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wait_reg <= 1'b1;
			rdata_reg <= 32'h0000_0000;
		end else if (bus_req & wait_reg) begin
			wait_reg <= 1'b0;
			rdata_reg <= rd_mux;
		end else begin
			wait_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pattern_reg <= CTRL_PAT_RESET;
			speed_reg <= CTRL_SPEED_RESET;
			loop_reg <= LOOP_NONE;
			echo_en_reg <= 1'b0;
			reseed_reg <= 1'b0;
		end else begin
			reseed_reg <= wr_ctrl & (ctrl_new[CTRL_RESEED_BIT] | (ctrl_new[3:0] != pattern_reg));
			if (wr_ctrl) begin
				pattern_reg <= ctrl_new[CTRL_PAT_LSB +: 4];
				speed_reg <= ctrl_new[CTRL_SPEED_LSB +: 3];
				loop_reg <= ctrl_new[CTRL_LOOP_LSB +: 2];
				echo_en_reg <= ctrl_new[CTRL_ECHO_BIT];
			end
		end
	end

	// user symbols start as alternating commas
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			user_sym_reg[0] <= COMMA_POS;
			user_sym_reg[1] <= COMMA_NEG;
			user_sym_reg[2] <= COMMA_POS;
			user_sym_reg[3] <= COMMA_NEG;
		end else begin
			if (wr_u01) begin
				user_sym_reg[0] <= u01_new[SYM_W-1:0];
				user_sym_reg[1] <= u01_new[USER_HI_LSB +: SYM_W];
			end
			if (wr_u23) begin
				user_sym_reg[2] <= u23_new[SYM_W-1:0];
				user_sym_reg[3] <= u23_new[USER_HI_LSB +: SYM_W];
			end
		end
	end

	//==========================================================
	// echo buffer
	logic [ECHO_AW:0] wr_ptr_reg;
	logic [ECHO_AW:0] rd_ptr_reg;
	logic rd_valid_reg;
	logic [WORD_W-1:0] echo_hold_reg;
	wire [WORD_W-1:0] echo_q;

	assign echo_level = wr_ptr_reg - rd_ptr_reg;
	wire echo_full = echo_level[ECHO_AW];
	wire echo_empty = (echo_level == '0);
	wire echo_push = echo_en_reg & rx_word_valid & ~echo_full;
	wire echo_drop = echo_en_reg & rx_word_valid & echo_full;
	wire echo_pop = echo_en_reg & ~echo_empty;
	wire echo_starve = echo_en_reg & echo_empty;

	ptg_echo_mem u_mem (
		.clk(clk),
		.wr_en(echo_push),
		.wr_addr(wr_ptr_reg[ECHO_AW-1:0]),
		.wr_data(rx_word),
		.rd_addr(rd_ptr_reg[ECHO_AW-1:0]),
		.rd_data(echo_q)
	);

	// full buffer drops the new word, empty buffer repeats the last one
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			rd_valid_reg <= 1'b0;
			echo_hold_reg <= '0;
		end else begin
			if (echo_push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (echo_pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			rd_valid_reg <= echo_pop;
			if (rd_valid_reg) begin
				echo_hold_reg <= echo_q;
			end
		end
	end

	// sticky slip flags, a new event beats a clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ovf_reg <= 1'b0;
			unf_reg <= 1'b0;
		end else begin
			ovf_reg <= echo_drop | (ovf_reg & ~(wr_stat & stat_clr[STAT_OVF_BIT]));
			unf_reg <= echo_starve | (unf_reg & ~(wr_stat & stat_clr[STAT_UNF_BIT]));
		end
	end

	//==========================================================
	// pattern generation
	wire wide = ptg_is_wide(speed_reg);
	logic [4:0] tap_n;
	logic [4:0] tap_k;
	logic invert;
	always_comb begin
		invert = 1'b0;
		case (ptg_pattern_t'(pattern_reg))
			PTG_PRBS7: begin tap_n = 5'd7; tap_k = 5'd6; end
			PTG_PRBS9: begin tap_n = 5'd9; tap_k = 5'd5; end
			PTG_PRBS11: begin tap_n = 5'd11; tap_k = 5'd9; end
			PTG_PRBS15: begin tap_n = 5'd15; tap_k = 5'd14; invert = 1'b1; end
			PTG_PRBS20: begin tap_n = 5'd20; tap_k = 5'd3; end
			PTG_PRBS23: begin tap_n = 5'd23; tap_k = 5'd18; invert = 1'b1; end
			PTG_PRBS29: begin tap_n = 5'd29; tap_k = 5'd27; invert = 1'b1; end
			PTG_PRBS31: begin tap_n = 5'd31; tap_k = 5'd28; invert = 1'b1; end
			default: begin tap_n = 5'd7; tap_k = 5'd6; end
		endcase
	end

	wire [LFSR_W+WORD_W-1:0] prbs_out = prbs_step(lfsr_reg, tap_n, tap_k, wide);
	wire [WORD_W-1:0] prbs_word = prbs_out[WORD_W-1:0] ^ {WORD_W{invert}};
	wire [WORD_W-1:0] idle_word = {COMMA_NEG, COMMA_POS, COMMA_NEG, COMMA_POS};
	wire [WORD_W-1:0] user_word = {user_sym_reg[3], user_sym_reg[2], user_sym_reg[1], user_sym_reg[0]};

	logic [WORD_W-1:0] pat_word;
	always_comb begin
		case (ptg_pattern_t'(pattern_reg))
			PTG_CLK2: pat_word = CLK2_WORD;
			PTG_CLK10: pat_word = CLK10_WORD;
			PTG_CLK20: pat_word = CLK20_WORD;
			PTG_PRBS7, PTG_PRBS9, PTG_PRBS11, PTG_PRBS15, PTG_PRBS20,
			PTG_PRBS23, PTG_PRBS29, PTG_PRBS31: pat_word = prbs_word;
			PTG_IDLE: pat_word = idle_word;
			PTG_USER: pat_word = user_word;
			default: pat_word = '0;
		endcase
	end

	wire [WORD_W-1:0] narrow_mask = {{(WORD_W-NARROW_W){wide}}, {NARROW_W{1'b1}}};
	wire [WORD_W-1:0] echo_word = rd_valid_reg ? echo_q : echo_hold_reg;
	wire [WORD_W-1:0] tx_next = (echo_en_reg ? echo_word : pat_word) & narrow_mask;

	// clk is the transceiver's transmit output clock, no divider needed
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lfsr_reg <= LFSR_SEED;
			tx_reg <= '0;
		end else begin
			if (reseed_reg) begin
				lfsr_reg <= LFSR_SEED;
			end else begin
				lfsr_reg <= prbs_out[WORD_W +: LFSR_W];
			end
			tx_reg <= tx_next;
		end
	end

	// loopback code goes out unchanged: 01/10 serial, 11 parallel
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wide_reg <= 1'b0;
			loop_out_reg <= LOOP_NONE;
			edge_reg <= 1'b0;
		end else begin
			wide_reg <= wide;
			loop_out_reg <= loop_reg;
			edge_reg <= 1'(CHANNEL_INDEX % 2);
		end
	end

	//==========================================================
	// outputs
	assign avs_readdata = rdata_reg;
	assign avs_waitrequest = wait_reg;
	assign tx_word = tx_reg;
	assign tx_wide_group = wide_reg;
	assign loopback_sel = loop_out_reg;
	assign edge_top = edge_reg;

endmodule

/* verification/ptg_chk.sv */
// port assertions for the test pattern generator
`timescale 1ns/100ps
module ptg_chk
	import ptg_pkg::*;
#(
	parameter int CHANNEL_INDEX = 0
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic avs_waitrequest,
	input wire logic [WORD_W-1:0] tx_word,
	input wire logic tx_wide_group,
	input wire logic [1:0] loopback_sel,
	input wire logic edge_top
);
	localparam logic [WORD_W-1:0] IDLE_W = {COMMA_NEG, COMMA_POS, COMMA_NEG, COMMA_POS};
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// control word committed, echo off
	sequence ctrl_wr(p);
		avs_write && !avs_waitrequest && avs_address == OFF_CTRL && avs_byteenable == 4'hF && !avs_writedata[9] && p;
	endsequence
	wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low two cycles");
	wait_cause_a: assert property (!avs_waitrequest |-> $past(avs_read || avs_write)) else $error("spurious answer");
	wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("answer late");
	edge_place_a: assert property ($past(!rst) |-> edge_top == (CHANNEL_INDEX % 2 == 1))
		else $error("edge select wrong");
	wide_set_a: assert property (ctrl_wr(1'b1) |-> ##3 tx_wide_group == $past(avs_writedata[6], 3))
		else $error("width group wrong");
	narrow_zero_a: assert property (!tx_wide_group && $past(!tx_wide_group) && $past(!tx_wide_group, 2)
		|-> tx_word[39:20] == 20'h0) else $error("narrow word upper bits set");
	loop_code_a: assert property (ctrl_wr(1'b1) |-> ##3 loopback_sel == $past(avs_writedata[8:7], 3))
		else $error("loopback code wrong");
	rsvd_zero_a: assert property (ctrl_wr(avs_writedata[3:0] == 4'hB || avs_writedata[3:0] > 4'hD)
		|-> ##3 tx_word == '0) else $error("reserved pattern not zero");
	idle_comma_a: assert property (ctrl_wr(avs_writedata[3:0] == 4'hC)
		|-> ##3 tx_word == (IDLE_W & {{20{$past(avs_writedata[6], 3)}}, 20'hF_FFFF})) else $error("idle word wrong");
endmodule

bind ptg_top ptg_chk #(.CHANNEL_INDEX(CHANNEL_INDEX)) u_ptg_chk (.clk, .rst, .avs_address, .avs_read, .avs_write,
	.avs_writedata, .avs_byteenable, .avs_waitrequest, .tx_word, .tx_wide_group, .loopback_sel, .edge_top);

/* verification/ptg_xcvr_model.sv */
// receive side of the transceiver: counting words, full or half rate
`timescale 1ns/100ps
module ptg_xcvr_model
	import ptg_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic run,
	input wire logic slow,
	output logic [WORD_W-1:0] rx_word,
	output logic rx_word_valid
);
	logic [WORD_W-1:0] count_reg;
	logic phase_reg;
	wire logic send = run && (!slow || phase_reg);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count_reg <= '0;
			phase_reg <= 1'b0;
			rx_word <= '0;
			rx_word_valid <= 1'b0;
		end else begin
			phase_reg <= ~phase_reg;
			rx_word_valid <= send;
			count_reg <= count_reg + 40'h1;
			// idle cycles scramble the data so stale words never match
			rx_word <= send ? count_reg : ~rx_word;
		end
	end
endmodule

/* verification/test_ptg_top.sv */
// self-checking bench for the test pattern generator
`timescale 1ns/100ps
module test_ptg_top;
	import ptg_pkg::*;
	logic clk, rst, avs_read, avs_write, avs_waitrequest, rx_word_valid, tx_wide_group, edge_top, run, slow;
	logic [3:0] avs_address, avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, d;
	logic [WORD_W-1:0] rx_word, tx_word;
	logic [1:0] loopback_sel;
	int err_count = 0;
	int total_checks = 0;
	int cycles = 0;
	ptg_top #(.CHANNEL_INDEX(1)) u_ptg_top (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_word(rx_word),
		.rx_word_valid(rx_word_valid), .tx_word(tx_word), .tx_wide_group(tx_wide_group),
		.loopback_sel(loopback_sel), .edge_top(edge_top));
	ptg_xcvr_model u_ptg_xcvr_model (.clk(clk), .rst(rst), .run(run), .slow(slow), .rx_word(rx_word),
		.rx_word_valid(rx_word_valid));
	//==========================================================
	// helpers
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic wait_ack();
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
	endtask
	task automatic bus_write(input logic [3:0] a, input logic [31:0] v, input logic [3:0] be);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= v;
		avs_byteenable <= be;
		avs_write <= 1'b1;
		wait_ack();
		avs_write <= 1'b0;
	endtask
	task automatic bus_read(input logic [3:0] a);
		@(posedge clk);
		avs_address <= a;
		avs_read <= 1'b1;
		wait_ack();
		d = avs_readdata;
		avs_read <= 1'b0;
	endtask
	task automatic ctrl_settle(input logic [31:0] v);
		bus_write(OFF_CTRL, v, 4'hF);
		repeat (3) @(negedge clk);
	endtask
	function automatic logic [WORD_W-1:0] clk_word(input int run_len, input logic wide);
		for (int i = 0; i < WORD_W; i++) begin
			clk_word[i] = (i < NARROW_W || wide) && (i / run_len) % 2 == 0;
		end
	endfunction
	//==========================================================
	// scenarios
	task automatic t_reset();
		repeat (2) @(negedge clk);
		check(tx_word, 40'h5_5555);
		check(edge_top, 1'b1);
		bus_read(OFF_USER01);
		check(d, 32'h0305_00FA);
		bus_read(OFF_USER23);
		check(d, 32'h0305_00FA);
		bus_read(OFF_STATUS);
		check(d & 32'h0000_0009, 32'h0000_0008);
		bus_read(4'h3);
		check(d, 32'h0000_0000);
	endtask
	task automatic t_clock();
		for (int p = 0; p < 6; p++) begin
			ctrl_settle({25'h0, p[0], 2'h0, 4'(p / 2)});
			check(tx_word, clk_word(p < 2 ? 1 : (p / 2) * 5, p[0]));
			check(tx_wide_group, p[0]);
		end
	endtask
	task automatic t_symbols();
		ctrl_settle(32'h0000_004D);
		check(tx_word, {COMMA_NEG, COMMA_POS, COMMA_NEG, COMMA_POS});
		// user symbols mixed, never all zero or all one
		bus_write(OFF_USER01, 32'h0123_0321, 4'h3);
		bus_write(OFF_USER23, 32'h02AA_0155, 4'hF);
		repeat (3) @(negedge clk);
		check(tx_word, {10'h2AA, 10'h155, COMMA_NEG, 10'h321});
		bus_read(OFF_USER01);
		check(d, 32'h0305_0321);
		ctrl_settle(32'h0000_000C);
		check(tx_word, {20'h0, COMMA_NEG, COMMA_POS});
		ctrl_settle(32'h0000_004F);
		check(tx_word, 40'h0);
	endtask
	task automatic t_prbs(input logic [3:0] pat, input int n, input int k, input logic inv, input logic wide);
		logic [159:0] b;
		int bad, ones, len;
		bad = 0;
		ones = 0;
		len = wide ? 160 : 80;
		ctrl_settle({25'h0, wide, 2'h0, pat});
		for (int t = 0; t < len; t++) begin
			if (t % (len / 4) == 0) @(negedge clk);
			b[t] = tx_word[t % (len / 4)];
			ones += b[t];
		end
		// the stream must obey its own feedback recurrence
		for (int t = n; t < len; t++) bad += (b[t] !== (b[t - n] ^ b[t - k] ^ inv));
		check(bad + (ones == 0 || ones == len), 0);
	endtask
	task automatic t_loop();
		for (int c = 0; c < 4; c++) begin
			ctrl_settle({23'h0, c[1:0], 7'h0});
			check(loopback_sel, c[1:0]);
		end
	endtask
	task automatic t_echo();
		logic [WORD_W-1:0] w;
		int bad;
		bad = 0;
		bus_write(OFF_CTRL, 32'h0000_0240, 4'hF);
		run <= 1'b1;
		repeat (20) @(posedge clk);
		bus_write(OFF_STATUS, 32'h0000_0006, 4'hF);
		@(negedge clk);
		w = tx_word;
		repeat (6) begin
			@(negedge clk);
			bad += (tx_word !== w + 40'h1);
			w = tx_word;
		end
		check(bad, 0);
		bus_read(OFF_STATUS);
		check(d[2:1], 2'h0);
		slow <= 1'b1;
		repeat (40) @(posedge clk);
		bus_read(OFF_STATUS);
		check(d[2], 1'b1);
		bus_write(OFF_CTRL, 32'h0000_0040, 4'hF);
		bus_write(OFF_STATUS, 32'h0000_0006, 4'hF);
		bus_read(OFF_STATUS);
		check(d[2:1], 2'h0);
	endtask
	//==========================================================
	// clock, reset, timeout, sequence
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			tally_and_finish();
		end
	end
	initial begin
		rst = 1'b1;
		{avs_read, avs_write, run, slow} = 4'h0;
		avs_address = 4'h0;
		avs_byteenable = 4'h0;
		avs_writedata = 32'h0000_0000;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_clock();
		t_symbols();
		t_prbs(4'h3, 7, 6, 1'b0, 1'b0);
		t_prbs(4'h3, 7, 6, 1'b0, 1'b1);
		t_prbs(4'h4, 9, 5, 1'b0, 1'b1);
		t_prbs(4'h5, 11, 9, 1'b0, 1'b1);
		t_prbs(4'h6, 15, 14, 1'b1, 1'b1);
		t_prbs(4'h7, 20, 3, 1'b0, 1'b1);
		t_prbs(4'h8, 23, 18, 1'b1, 1'b1);
		t_prbs(4'h9, 29, 27, 1'b1, 1'b1);
		t_prbs(4'hA, 31, 28, 1'b1, 1'b1);
		t_loop();
		t_echo();
		tally_and_finish();
	end
endmodule
